/* File: pkg/cch_cfg.svh */
`ifndef CCH_CFG_SVH
`define CCH_CFG_SVH

`define CCH_SEL_W 4
`define CCH_SEL_AS 4'h2
`define CCH_SEL_JTAG_ONLY 4'h0
`define CCH_INIT_CYCLES 3180
`define CCH_CNT_W 12

`endif

/* File: pkg/cch_pkg.sv */
package cch_pkg;
    typedef enum logic [2:0] {
        CCH_IDLE,
        CCH_AS_LOAD,
        CCH_JTAG_LOAD,
        CCH_JTAG_INIT,
        CCH_DONE,
        CCH_ERROR
    } cch_state_t;

    typedef struct packed {
        logic drv_o;
        logic oe_o;
    } cch_od_t;

    typedef struct packed {
        logic start;
        logic last_bit;
        logic compressed;
        logic crc_err;
    } cch_jtag_ev_t;
endpackage : cch_pkg

/* File: design/cch_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module cch_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // first stage read only by the second
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d_in;
            q_r <= meta_r;
        end
    end

    assign q_out = q_r;
endmodule : cch_sync
`default_nettype wire

/* File: design/cch_chain_ctrl.sv */
// Notes on behaviour
// - finished device drives chain-enable output low to start the next device
// - devices sharing done and status lines enter user mode together
// - after good JTAG load, chain-enable output goes low
// - JTAG load wins over active serial load, which is aborted
// - no bitstream decompression under JTAG; host sends uncompressed data
// - good JTAG load releases configuration-complete so it rises
`timescale 1ns/10ps
`default_nettype none
`include "cch_cfg.svh"
module cch_chain_ctrl
    import cch_pkg::*;
#(
    parameter int INIT_CYCLES = `CCH_INIT_CYCLES
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic jtag_clk_in,
    input wire logic chain_en_n_in,
    input wire logic [`CCH_SEL_W-1:0] scheme_select_in,
    input wire logic reconfig_n_in,
    input wire logic jtag_start_in,
    input wire logic jtag_last_bit_in,
    input wire logic jtag_compressed_in,
    input wire logic jtag_crc_err_in,
    input wire logic as_done_in,
    input wire logic as_err_in,
    input wire logic configuration_complete_in,
    input wire logic status_n_in,
    output logic chain_en_n_out,
    output logic configuration_complete_out,
    output logic configuration_complete_oe_out,
    output logic status_n_out,
    output logic status_n_oe_out,
    output logic as_active_out,
    output logic as_abort_out,
    output logic decompress_en_out,
    output logic user_mode_out
);
    logic [6:0] raw_w;
    logic [6:0] sy_w;
    logic tck_d_r;
    logic tck_rise_w;
    cch_jtag_ev_t ev_w;
    logic en_n_w;
    logic cc_line_w;
    logic st_line_w;
    logic [3:0] sel_w;
    logic sel_as_w;
    cch_state_t state_r;
    cch_state_t state_nxt;
    logic [`CCH_CNT_W-1:0] init_cnt_r;
    logic [`CCH_CNT_W-1:0] init_cnt_nxt;
    logic chain_en_n_r;
    logic cc_oe_r;
    logic st_oe_r;
    logic as_active_r;
    logic as_abort_r;
    logic decomp_r;
    logic user_r;
    logic init_end_w;
    logic [`CCH_SEL_W-1:0] sel_r;
    cch_od_t cc_od_w;
    cch_od_t st_od_w;

    // pins cross into clk_in through two flops
    assign raw_w = {jtag_clk_in, chain_en_n_in, jtag_start_in, jtag_last_bit_in,
                    jtag_compressed_in, jtag_crc_err_in, configuration_complete_in};

    cch_sync #(.W(7)) u_sync_ctl (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .d_in(raw_w),
        .q_out(sy_w)
    );

    cch_sync #(.W(`CCH_SEL_W)) u_sync_sel (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .d_in(scheme_select_in),
        .q_out(sel_r)
    );

    logic st_sync_w;
    cch_sync #(.W(1)) u_sync_st (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .d_in(status_n_in),
        .q_out(st_sync_w)
    );

    // strap is static on the board but still a pin, so it crosses like the rest
    logic rcfg_sync_w;
    cch_sync #(.W(1)) u_sync_rcfg (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .d_in(reconfig_n_in),
        .q_out(rcfg_sync_w)
    );

    assign tck_rise_w = sy_w[6] & ~tck_d_r;
    assign en_n_w = sy_w[5];
    assign ev_w.start = sy_w[4];
    assign ev_w.last_bit = sy_w[3];
    assign ev_w.compressed = sy_w[2];
    assign ev_w.crc_err = sy_w[1];
    assign cc_line_w = sy_w[0];
    assign st_line_w = st_sync_w;
    assign sel_w = sel_r;
    assign sel_as_w = (sel_w == `CCH_SEL_AS);
    assign init_end_w = tck_rise_w && (init_cnt_r == '0);

    // next state
    always_comb begin
        state_nxt = state_r;
        init_cnt_nxt = init_cnt_r;
        unique case (state_r)
            CCH_IDLE: begin
                if (ev_w.start) begin
                    state_nxt = CCH_JTAG_LOAD;
                end else if (sel_as_w && !en_n_w && rcfg_sync_w) begin
                    state_nxt = CCH_AS_LOAD;
                end
            end
            CCH_AS_LOAD: begin
                if (ev_w.start) begin
                    state_nxt = CCH_JTAG_LOAD;
                end else if (as_err_in) begin
                    state_nxt = CCH_ERROR;
                end else if (as_done_in) begin
                    state_nxt = CCH_DONE;
                end
            end
            CCH_JTAG_LOAD: begin
                // compressed data cannot be unpacked here, so treat as failure
                if (ev_w.crc_err || ev_w.compressed) begin
                    state_nxt = CCH_ERROR;
                end else if (ev_w.last_bit) begin
                    state_nxt = CCH_JTAG_INIT;
                    init_cnt_nxt = `CCH_CNT_W'(INIT_CYCLES - 1);
                end
            end
            CCH_JTAG_INIT: begin
                // initialization advances only on jtag clock edges
                if (tck_rise_w) begin
                    if (init_end_w) begin
                        state_nxt = CCH_DONE;
                    end else begin
                        init_cnt_nxt = init_cnt_r - `CCH_CNT_W'(1);
                    end
                end
            end
            CCH_DONE: begin
                if (ev_w.start) begin
                    state_nxt = CCH_JTAG_LOAD;
                end
            end
            CCH_ERROR: begin
                if (ev_w.start) begin
                    state_nxt = CCH_JTAG_LOAD;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_r <= CCH_IDLE;
            init_cnt_r <= '0;
            tck_d_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            init_cnt_r <= init_cnt_nxt;
            tck_d_r <= sy_w[6];
        end
    end

    // outputs registered
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            chain_en_n_r <= 1'b1;
            cc_oe_r <= 1'b1;
            st_oe_r <= 1'b0;
            as_active_r <= 1'b0;
            as_abort_r <= 1'b0;
            decomp_r <= 1'b0;
            user_r <= 1'b0;
        end else begin
            chain_en_n_r <= !(state_nxt == CCH_DONE);
            cc_oe_r <= !(state_nxt == CCH_DONE);
            st_oe_r <= (state_nxt == CCH_ERROR);
            as_active_r <= (state_nxt == CCH_AS_LOAD);
            as_abort_r <= (state_r == CCH_AS_LOAD) && (state_nxt == CCH_JTAG_LOAD);
            decomp_r <= (state_nxt == CCH_AS_LOAD);
            // user mode waits for the shared lines, so the chain wakes as one
            // same next-state source as the handoff, so user mode never outlives it
            user_r <= (state_nxt == CCH_DONE) && cc_line_w && st_line_w;
        end
    end

    // open drain: drive only low, never high
    assign cc_od_w = '{drv_o: 1'b0, oe_o: cc_oe_r};
    assign st_od_w = '{drv_o: 1'b0, oe_o: st_oe_r};

    assign chain_en_n_out = chain_en_n_r;
    assign configuration_complete_out = cc_od_w.drv_o;
    assign configuration_complete_oe_out = cc_od_w.oe_o;
    assign status_n_out = st_od_w.drv_o;
    assign status_n_oe_out = st_od_w.oe_o;
    assign as_active_out = as_active_r;
    assign as_abort_out = as_abort_r;
    assign decompress_en_out = decomp_r;
    assign user_mode_out = user_r;
endmodule : cch_chain_ctrl
`default_nettype wire

/* File: dv/cch_jtag_host.sv */
`timescale 1ns/10ps
`default_nettype none
module cch_jtag_host (
    input wire logic run_in,
    output logic tck_out
);
    initial tck_out = 1'b0;
    // odd start offset keeps the link clock out of phase with clk_in
    initial begin
        #137;
        forever begin
            #400;
            tck_out = run_in ? ~tck_out : 1'b0;
        end
    end
endmodule : cch_jtag_host
`default_nettype wire

/* File: dv/cch_chain_ctrl_props.sv */
`timescale 1ns/10ps
`default_nettype none
module cch_chain_ctrl_props (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic chain_en_n_out,
    input wire logic configuration_complete_out,
    input wire logic configuration_complete_oe_out,
    input wire logic status_n_out,
    input wire logic as_active_out,
    input wire logic as_abort_out,
    input wire logic decompress_en_out,
    input wire logic user_mode_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    cc_drive_a: assert property (configuration_complete_out == 1'b0)
        else $error("done pin driven high");
    st_drive_a: assert property (status_n_out == 1'b0)
        else $error("status pin driven high");
    decomp_as_a: assert property (decompress_en_out |-> as_active_out)
        else $error("decompression outside serial load");
    abort_one_a: assert property (as_abort_out |=> !as_abort_out)
        else $error("abort longer than one cycle");
    abort_src_a: assert property (as_abort_out |-> $past(as_active_out) && !as_active_out)
        else $error("abort without serial load");
    handoff_a: assert property (chain_en_n_out == configuration_complete_oe_out)
        else $error("handoff and done release differ");
    user_mode_a: assert property (user_mode_out |-> !chain_en_n_out)
        else $error("user mode before done");
endmodule : cch_chain_ctrl_props
bind cch_chain_ctrl cch_chain_ctrl_props chk (.clk_in, .srst_in, .chain_en_n_out,
    .configuration_complete_out, .configuration_complete_oe_out, .status_n_out,
    .as_active_out, .as_abort_out, .decompress_en_out, .user_mode_out);
`default_nettype wire

/* File: dv/cch_chain_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module cch_chain_ctrl_tb;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic run = 1'b0;
    logic cmp = 1'b0;
    logic ext_done = 1'b1;
    logic cen_in_n = 1'b0;
    logic crc = 1'b0;
    logic as_done = 1'b0;
    logic as_err = 1'b0;
    logic [1:0] ev = 2'h0;
    logic [3:0] sel = 4'h0;
    logic tck, cen_n, cc_out, cc_oe, st_out, st_oe, as_act, as_abt, dec, um;
    int error_cnt = 0;
    int checks = 0;
    always #50 clk_in = ~clk_in;
    cch_jtag_host host (.run_in(run), .tck_out(tck));
    cch_chain_ctrl #(.INIT_CYCLES(4)) dut (.clk_in(clk_in), .srst_in(srst_in),
        .jtag_clk_in(tck), .chain_en_n_in(cen_in_n), .scheme_select_in(sel),
        .reconfig_n_in(1'b1), .jtag_start_in(ev[0]), .jtag_last_bit_in(ev[1]),
        .jtag_compressed_in(cmp), .jtag_crc_err_in(crc), .as_done_in(as_done),
        .as_err_in(as_err), .configuration_complete_in(ext_done & ~cc_oe),
        .status_n_in(~st_oe), .chain_en_n_out(cen_n), .configuration_complete_out(cc_out),
        .configuration_complete_oe_out(cc_oe), .status_n_out(st_out),
        .status_n_oe_out(st_oe), .as_active_out(as_act), .as_abort_out(as_abt),
        .decompress_en_out(dec), .user_mode_out(um));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    task automatic chk(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_on(input int k);
        int n;
        logic v;
        n = 0;
        v = 1'b0;
        while (v !== 1'b1 && n < 300) begin
            @(posedge clk_in);
            #1;
            v = (k == 0) ? ~cen_n : (k == 1) ? as_act : (k == 2) ? as_abt : st_oe;
            n++;
        end
        if (v !== 1'b1) begin
            error_cnt++;
            complete_run();
        end
    endtask : wait_on
    task automatic rst(input logic [3:0] s);
        sel <= s;
        srst_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        srst_in <= 1'b0;
    endtask : rst
    task automatic jtag_ok();
        ext_done <= 1'b0;
        ev <= 2'h1;
        repeat (4) @(posedge clk_in);
        ev <= 2'h2;
        repeat (4) @(posedge clk_in);
        ev <= 2'h0;
        run <= 1'b1;
        wait_on(0);
        run <= 1'b0;
        chk(cc_oe, 1'b0);
        chk(dec, 1'b0);
        chk(cc_out, 1'b0);
        repeat (8) @(posedge clk_in);
        chk(um, 1'b0);
        ext_done <= 1'b1;
        repeat (8) @(posedge clk_in);
        chk(um, 1'b1);
        $display("test jtag_ok done");
    endtask : jtag_ok
    task automatic as_preempt();
        rst(4'h2);
        wait_on(1);
        chk(dec, 1'b1);
        ev <= 2'h1;
        wait_on(2);
        chk(as_act, 1'b0);
        chk(dec, 1'b0);
        ev <= 2'h0;
        $display("test as_preempt done");
    endtask : as_preempt
    task automatic bad_stream();
        rst(4'h0);
        cmp <= 1'b1;
        ev <= 2'h1;
        wait_on(3);
        chk(cen_n, 1'b1);
        chk(um, 1'b0);
        chk(st_out, 1'b0);
        cmp <= 1'b0;
        rst(4'h0);
        crc <= 1'b1;
        wait_on(3);
        chk(cc_oe, 1'b1);
        crc <= 1'b0;
        ev <= 2'h0;
        $display("test bad_stream done");
    endtask : bad_stream
    task automatic serial_paths();
        cen_in_n <= 1'b1;
        rst(4'h2);
        repeat (10) @(posedge clk_in);
        chk(as_act, 1'b0);
        cen_in_n <= 1'b0;
        wait_on(1);
        as_done <= 1'b1;
        wait_on(0);
        as_done <= 1'b0;
        chk(as_act, 1'b0);
        repeat (8) @(posedge clk_in);
        chk(um, 1'b1);
        rst(4'h2);
        wait_on(1);
        as_err <= 1'b1;
        wait_on(3);
        chk(cen_n, 1'b1);
        as_err <= 1'b0;
        $display("test serial_paths done");
    endtask : serial_paths
    initial begin
        rst(4'h0);
        jtag_ok();
        as_preempt();
        bad_stream();
        serial_paths();
        complete_run();
    end
endmodule : cch_chain_ctrl_tb
`default_nettype wire
